// file: include/stpe_map.vh
// Constants of the storage test pattern engine
`ifndef STPE_MAP_VH
`define STPE_MAP_VH
// ****************************************************************
// Buffer geometry
// ****************************************************************
`define STPE_WORD_W 128
`define STPE_FIFO_AW 12
`define STPE_FIFO_DEPTH 13'h1000
`define STPE_CNT_W 13
// ****************************************************************
// Burst and threshold counts, in 128-bit words
// ****************************************************************
`define STPE_BURST_PREP_LAST 9'h1fe
`define STPE_GEN_SPACE_LIMIT 13'hc00
`define STPE_CMD_DATA_MIN 13'h200
`define STPE_CMD_CONT_MIN 13'h220
// ****************************************************************
// Transfer parameters
// ****************************************************************
`define STPE_ADDR_W 48
`define STPE_LEN_W 32
`define STPE_BLK_W 28
`define STPE_BLK_SHIFT 4
`define STPE_SECT_PER_BLOCK 48'h10
`define STPE_ONE_BLOCK 28'h1
// ****************************************************************
// Pattern selection codes and reset values
// ****************************************************************
`define STPE_PAT_INC 3'h0
`define STPE_PAT_DEC 3'h1
`define STPE_PAT_LFSR 3'h2
`define STPE_PAT_ZERO 3'h3
`define STPE_PAT_ONE 3'h4
`define STPE_INC_SEED 32'h00000000
`define STPE_LFSR_SEED 32'h00000001
`endif

// file: hdl/stpe_fifo.v
// Show-ahead test data buffer with occupancy counter
`timescale 1ns/1ns
`include "stpe_map.vh"
module stpe_fifo (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire wr_en,
  input wire [127:0] wr_data,
  output reg full,
  input wire rd_ack,
  output reg [127:0] rd_data,
  output reg rd_valid,
  output reg [12:0] fill_count
);
  reg [127:0] mem [0:4095];
  reg [11:0] wp;
  reg [11:0] rp;
  reg [12:0] mem_cnt;
  wire push = wr_en && (mem_cnt != `STPE_FIFO_DEPTH);
  wire ack = rd_ack && rd_valid;
  wire pop = (mem_cnt != 13'h0) && (!rd_valid || ack);
  wire [12:0] next_mem_cnt = mem_cnt + {12'h0, push} - {12'h0, pop};

  always @(posedge clk) begin
    if (push) begin
      mem[wp] <= wr_data;
    end
  end

  // Output word is a register loaded ahead, so the head is always shown
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 12'h0;
      rp <= 12'h0;
      mem_cnt <= 13'h0;
      fill_count <= 13'h0;
      full <= 1'b0;
      rd_data <= 128'h0;
      rd_valid <= 1'b0;
    end else if (clear) begin
      wp <= 12'h0;
      rp <= 12'h0;
      mem_cnt <= 13'h0;
      fill_count <= 13'h0;
      full <= 1'b1;
      rd_valid <= 1'b0;
    end else begin
      if (push) begin
        wp <= wp + 12'h1;
      end
      if (pop) begin
        rp <= rp + 12'h1;
        rd_data <= mem[rp];
        rd_valid <= 1'b1;
      end else if (ack) begin
        rd_valid <= 1'b0;
      end
      mem_cnt <= next_mem_cnt;
      fill_count <= fill_count + {12'h0, push} - {12'h0, ack};
      full <= (next_mem_cnt == `STPE_FIFO_DEPTH);
    end
  end
endmodule // stpe_fifo

// file: hdl/stpe_engine.v
// Storage test pattern engine: data generator, command and verify
// ****************************************************************
// Summary of operation
// - Request captures length, start sector, pattern select
// - Generator pulses buffer clear for one cycle
// - Then waits until buffer full drops
// - New burst needs two bursts free space
// - One header cycle opens each burst
// - Write enable high 512 cycles, words precomputed
// - Final block returns generator to idle
// - Low space ends burst, waits for space
// - Count below 3072 continues straight to header
// - Show-ahead buffer holds 64 Kbytes, eight bursts
// - Request raises test busy, picks read/write path
// - Read issues one command per block, then waits
// - Write waits for one full burst buffered
// - Read ack when write accepted; buffer drives data
// - First cycle shows word, address, write command
// - After 511th accepted word go to check
// - Short buffer drops write command, waits data
// - Enough data continues next write without gap
// - Final block drops write, enters end wait
// - Every command moves exactly 8 Kbytes
// - Read mode compares returned data with buffer
// - End wait clears busy when registered busy low
// - Read valid pops buffer; mismatch sets sticky fail
// - Back-to-back write needs count above 544
// - Hold address and data while wait request high
// ****************************************************************
`timescale 1ns/1ns
`include "stpe_map.vh"
module stpe_engine (
  input wire ref_clk,
  input wire rst_n,
  input wire write_test_request,
  input wire read_test_request,
  input wire [31:0] total_sector_count,
  input wire [47:0] start_sector_addr,
  input wire [2:0] pattern_select,
  output reg test_busy_out,
  output reg verify_fail_flag,
  output reg write_cmd_out,
  output reg read_cmd_out,
  output reg [47:0] cmd_block_addr,
  output wire [127:0] write_word_out,
  input wire [127:0] read_word_in,
  input wire read_word_valid,
  input wire ctrl_wait_request,
  input wire ctrl_busy_flag
);
  localparam [2:0] gen_idle = 3'h0;
  localparam [2:0] gen_clear = 3'h1;
  localparam [2:0] gen_wait_clear = 3'h2;
  localparam [2:0] gen_wait_space = 3'h3;
  localparam [2:0] gen_header = 3'h4;
  localparam [2:0] gen_burst = 3'h5;
  localparam [2:0] cmd_idle = 3'h0;
  localparam [2:0] cmd_read_issue = 3'h1;
  localparam [2:0] cmd_wait_data = 3'h2;
  localparam [2:0] cmd_write_burst = 3'h3;
  localparam [2:0] cmd_last_word_check = 3'h4;
  localparam [2:0] cmd_wait_done = 3'h5;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg [1:0] rst_sync;
  wire rst_n_int = rst_sync[1];
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  wire request = write_test_request || read_test_request;
  wire [27:0] req_blocks =
    total_sector_count[`STPE_LEN_W-1:`STPE_BLK_SHIFT];

  // ****************************************************************
  // Test data buffer
  // ****************************************************************
  reg buffer_clear;
  reg buffer_write_en;
  reg [127:0] gen_word;
  wire buffer_full;
  wire [12:0] buffer_fill_count;
  wire buffer_read_ack;
  wire [127:0] buffer_read_word;
  reg read_mode;

  // The buffer output register is the write data bus itself
  stpe_fifo u_buffer (
    .clk(ref_clk),
    .rst_n(rst_n_int),
    .clear(buffer_clear),
    .wr_en(buffer_write_en),
    .wr_data(gen_word),
    .full(buffer_full),
    .rd_ack(buffer_read_ack),
    .rd_data(buffer_read_word),
    .rd_valid(),
    .fill_count(buffer_fill_count)
  );
  assign write_word_out = buffer_read_word;
  assign buffer_read_ack = read_mode ? read_word_valid :
    (write_cmd_out && !ctrl_wait_request);
  // ****************************************************************
  // Pattern functions
  // ****************************************************************
  function [31:0] pat_step;
    input [2:0] sel;
    input [31:0] v;
    pat_step = (sel == `STPE_PAT_LFSR) ?
      {v[30:0], v[30] ^ v[20] ^ v[0]} : v + 32'h1;
  endfunction
  function [31:0] pat_out;
    input [2:0] sel;
    input [31:0] v;
    case (sel)
      `STPE_PAT_DEC: pat_out = ~v;
      `STPE_PAT_ZERO: pat_out = 32'h0;
      `STPE_PAT_ONE: pat_out = 32'hffffffff;
      default: pat_out = v;
    endcase
  endfunction
  reg [2:0] sel;
  reg [31:0] pat;
  reg [47:0] gen_addr;
  wire [31:0] pd1 = pat_step(sel, pat);
  wire [31:0] pd2 = pat_step(sel, pd1);
  wire [31:0] pd3 = pat_step(sel, pd2);
  wire [31:0] pd4 = pat_step(sel, pd3);
  wire no_header = (sel == `STPE_PAT_ZERO) || (sel == `STPE_PAT_ONE);
  wire [127:0] plain_word = {pat_out(sel, pd3), pat_out(sel, pd2),
    pat_out(sel, pd1), pat_out(sel, pat)};
  wire [127:0] head_word = {pat_out(sel, pd1), pat_out(sel, pat),
    16'h0, gen_addr[47:32], gen_addr[31:0]};

  // ****************************************************************
  // Data generator
  // ****************************************************************
  reg [2:0] gen_fsm;
  reg [8:0] gen_idx;
  reg [27:0] gen_remaining_blocks;
  wire gen_space_ok = buffer_fill_count < `STPE_GEN_SPACE_LIMIT;

  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      gen_fsm <= gen_idle;
      gen_idx <= 9'h0;
      gen_remaining_blocks <= 28'h0;
      gen_addr <= 48'h0;
      sel <= `STPE_PAT_INC;
      pat <= `STPE_INC_SEED;
      gen_word <= 128'h0;
      buffer_clear <= 1'b0;
      buffer_write_en <= 1'b0;
    end else begin
      buffer_clear <= 1'b0;
      // Enable follows the state: the word prepared in the last burst
      // cycle is still written while the new state starts
      buffer_write_en <= (gen_fsm == gen_header) ||
        (gen_fsm == gen_burst);
      case (gen_fsm)
        gen_idle: begin
          if (request && (req_blocks != 28'h0)) begin
            gen_remaining_blocks <= req_blocks;
            gen_addr <= start_sector_addr;
            sel <= pattern_select;
            pat <= (pattern_select == `STPE_PAT_LFSR) ?
              `STPE_LFSR_SEED : `STPE_INC_SEED;
            buffer_clear <= 1'b1;
            gen_fsm <= gen_clear;
          end
        end
        gen_clear: begin
          gen_fsm <= gen_wait_clear;
        end
        gen_wait_clear: begin
          if (!buffer_full) begin
            gen_fsm <= gen_wait_space;
          end
        end
        gen_wait_space: begin
          if (gen_space_ok) begin
            gen_fsm <= gen_header;
          end
        end
        gen_header: begin
          gen_idx <= 9'h0;
          if (no_header) begin
            gen_word <= plain_word;
            pat <= pd4;
          end else begin
            gen_word <= head_word;
            pat <= pd2;
          end
          gen_addr <= gen_addr + `STPE_SECT_PER_BLOCK;
          gen_fsm <= gen_burst;
        end
        gen_burst: begin
          gen_word <= plain_word;
          pat <= pd4;
          gen_idx <= gen_idx + 9'h1;
          if (gen_idx == `STPE_BURST_PREP_LAST) begin
            gen_remaining_blocks <= gen_remaining_blocks - 28'h1;
            if (gen_remaining_blocks == `STPE_ONE_BLOCK) begin
              gen_fsm <= gen_idle;
            end else if (gen_space_ok) begin
              gen_fsm <= gen_header;
            end else begin
              gen_fsm <= gen_wait_space;
            end
          end
        end
        default: begin
          gen_fsm <= gen_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  reg [2:0] cmd_fsm;
  reg [8:0] cmd_idx;
  reg [27:0] cmd_remaining_blocks;
  reg busy_q;
  wire accepted = !ctrl_wait_request;
  wire cmd_final = cmd_remaining_blocks == `STPE_ONE_BLOCK;

  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      cmd_fsm <= cmd_idle;
      cmd_idx <= 9'h0;
      cmd_remaining_blocks <= 28'h0;
      busy_q <= 1'b0;
      read_mode <= 1'b0;
      test_busy_out <= 1'b0;
      write_cmd_out <= 1'b0;
      read_cmd_out <= 1'b0;
      cmd_block_addr <= 48'h0;
    end else begin
      busy_q <= ctrl_busy_flag;
      // Address and word change only on acceptance, so a wait request
      // holds both as they stand
      case (cmd_fsm)
        cmd_idle: begin
          if (request) begin
            cmd_remaining_blocks <= req_blocks;
            cmd_block_addr <= start_sector_addr;
            read_mode <= read_test_request;
            test_busy_out <= 1'b1;
            if (req_blocks == 28'h0) begin
              cmd_fsm <= cmd_wait_done;
            end else if (read_test_request) begin
              read_cmd_out <= 1'b1;
              cmd_fsm <= cmd_read_issue;
            end else begin
              cmd_fsm <= cmd_wait_data;
            end
          end
        end
        cmd_read_issue: begin
          if (accepted) begin
            cmd_remaining_blocks <= cmd_remaining_blocks - 28'h1;
            cmd_block_addr <= cmd_block_addr +
              `STPE_SECT_PER_BLOCK;
            if (cmd_final) begin
              read_cmd_out <= 1'b0;
              cmd_fsm <= cmd_wait_done;
            end
          end
        end
        cmd_wait_data: begin
          if (buffer_fill_count >= `STPE_CMD_DATA_MIN) begin
            write_cmd_out <= 1'b1;
            cmd_idx <= 9'h0;
            cmd_fsm <= cmd_write_burst;
          end
        end
        cmd_write_burst: begin
          if (accepted) begin
            cmd_idx <= cmd_idx + 9'h1;
            if (cmd_idx == `STPE_BURST_PREP_LAST) begin
              cmd_fsm <= cmd_last_word_check;
            end
          end
        end
        cmd_last_word_check: begin
          if (accepted) begin
            cmd_remaining_blocks <= cmd_remaining_blocks - 28'h1;
            cmd_block_addr <= cmd_block_addr +
              `STPE_SECT_PER_BLOCK;
            cmd_idx <= 9'h0;
            if (cmd_final) begin
              write_cmd_out <= 1'b0;
              cmd_fsm <= cmd_wait_done;
            end else if (buffer_fill_count > `STPE_CMD_CONT_MIN) begin
              // The counter lags the read ack, hence the margin
              cmd_fsm <= cmd_write_burst;
            end else begin
              write_cmd_out <= 1'b0;
              cmd_fsm <= cmd_wait_data;
            end
          end
        end
        cmd_wait_done: begin
          if (!busy_q) begin
            test_busy_out <= 1'b0;
            cmd_fsm <= cmd_idle;
          end
        end
        default: begin
          cmd_fsm <= cmd_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read data verification
  // ****************************************************************
  // A mismatch wins over the clear that a new request gives
  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      verify_fail_flag <= 1'b0;
    end else if (read_mode && read_word_valid &&
        (read_word_in != buffer_read_word)) begin
      verify_fail_flag <= 1'b1;
    end else if (request && (cmd_fsm == cmd_idle)) begin
      verify_fail_flag <= 1'b0;
    end
  end
endmodule // stpe_engine

// file: dv/stpe_engine_monitor.sv
// Port assertions for the test pattern engine
`timescale 1ns/1ns
module stpe_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire write_test_request,
  input wire read_test_request,
  input wire test_busy_out,
  input wire verify_fail_flag,
  input wire write_cmd_out,
  input wire read_cmd_out,
  input wire [47:0] cmd_block_addr,
  input wire [127:0] write_word_out,
  input wire read_word_valid,
  input wire ctrl_wait_request,
  input wire ctrl_busy_flag
);
  // Accepted write words, wrapping once per 512-word block
  reg [8:0] acc_cnt;
  wire wr_acc = write_cmd_out && !ctrl_wait_request;
  wire rd_acc = read_cmd_out && !ctrl_wait_request;
  wire req = write_test_request || read_test_request;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      acc_cnt <= 9'h000;
    else if (wr_acc)
      acc_cnt <= acc_cnt + 9'h001;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_busy_rise: assert property (
    !test_busy_out && req |=> test_busy_out)
    else $error("busy did not follow request");
  a_idle_quiet: assert property (
    !test_busy_out |-> !write_cmd_out && !read_cmd_out)
    else $error("command while not busy");
  a_busy_fall: assert property (
    $fell(test_busy_out) |-> !$past(ctrl_busy_flag))
    else $error("busy dropped while controller busy");
  a_read_step: assert property (
    rd_acc |=> cmd_block_addr == $past(cmd_block_addr) + 48'h10)
    else $error("read address did not step");
  a_read_hold: assert property (
    read_cmd_out && ctrl_wait_request |=>
      read_cmd_out && $stable(cmd_block_addr))
    else $error("read command not held");
  a_read_drop: assert property (
    $fell(read_cmd_out) |-> $past(rd_acc))
    else $error("read command dropped unaccepted");
  a_write_hold: assert property (
    write_cmd_out && ctrl_wait_request |=> write_cmd_out &&
      $stable(write_word_out) && $stable(cmd_block_addr))
    else $error("write not held during wait");
  a_write_step: assert property (
    wr_acc |=> cmd_block_addr == $past(cmd_block_addr) +
      (($past(acc_cnt) == 9'h1ff) ? 48'h10 : 48'h0))
    else $error("write address step wrong");
  a_write_whole: assert property (
    $fell(write_cmd_out) |-> acc_cnt == 9'h000)
    else $error("write dropped mid block");
  a_fail_cause: assert property (
    $rose(verify_fail_flag) |-> $past(read_word_valid))
    else $error("fail set without read data");
  a_fail_sticky: assert property (
    verify_fail_flag && !req |=> verify_fail_flag)
    else $error("fail flag not sticky");
endmodule // stpe_monitor
bind stpe_engine stpe_monitor u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n),
  .write_test_request(write_test_request),
  .read_test_request(read_test_request),
  .test_busy_out(test_busy_out), .verify_fail_flag(verify_fail_flag),
  .write_cmd_out(write_cmd_out), .read_cmd_out(read_cmd_out),
  .cmd_block_addr(cmd_block_addr), .write_word_out(write_word_out),
  .read_word_valid(read_word_valid),
  .ctrl_wait_request(ctrl_wait_request), .ctrl_busy_flag(ctrl_busy_flag)
);

// file: dv/stpe_ctrl_model.sv
// Behavioural storage controller facing the engine
`timescale 1ns/1ns
module stpe_ctrl_model (
  input wire ref_clk,
  input wire stall,
  input wire corrupt,
  input wire write_cmd_out,
  input wire read_cmd_out,
  input wire [127:0] write_word_out,
  output reg [127:0] read_word_in = 128'h0,
  output reg read_word_valid = 1'b0,
  output reg ctrl_wait_request = 1'b0,
  output reg ctrl_busy_flag = 1'b0
);
  // Words kept in acceptance order and replayed by reads
  reg [127:0] mem [0:8191];
  reg [12:0] wp = 13'h0;
  reg [12:0] rp = 13'h0;
  reg [13:0] pend = 14'h0;
  reg [5:0] lat = 6'h0;
  reg [5:0] idle = 6'h0;
  reg [2:0] ph = 3'h0;
  wire wr_acc = write_cmd_out && !ctrl_wait_request;
  wire rd_acc = read_cmd_out && !ctrl_wait_request;
  // Data comes back only after a latency, as from a real target
  wire ret = pend != 14'h0 && lat == 6'h3f;
  wire [13:0] owe = rd_acc ? 14'h200 : 14'h0;
  wire quiet = pend == 14'h0 && !write_cmd_out && !read_cmd_out;
  always @(posedge ref_clk) begin
    ph <= ph + 3'h1;
    // Stalls come in runs of four so holds span several edges
    ctrl_wait_request <= stall && ph[2];
    if (wr_acc)
      mem[ctrl_busy_flag ? wp : 13'h0] <= write_word_out;
    if (wr_acc)
      wp <= ctrl_busy_flag ? wp + 13'h1 : 13'h1;
    rp <= (rd_acc && !ctrl_busy_flag) ? 13'h0 : rp + {12'h0, ret};
    pend <= pend + owe - {13'h0, ret};
    read_word_valid <= ret;
    // Undriven data toggles so stale words never look valid
    if (ret)
      read_word_in <= mem[rp] ^ {127'h0, corrupt && rp == 13'h3};
    else
      read_word_in <= ~read_word_in;
    lat <= !ctrl_busy_flag ? 6'h0 : lat + {5'h0, lat != 6'h3f};
    idle <= (wr_acc || rd_acc || !quiet) ? 6'h0 : idle + 6'h1;
    if (wr_acc || rd_acc)
      ctrl_busy_flag <= 1'b1;
    else if (idle == 6'h3f)
      ctrl_busy_flag <= 1'b0;
  end
endmodule // stpe_ctrl_model

// file: dv/tb_top.sv
// Self-checking bench for the test pattern engine
`timescale 1ns/1ns
module tb_top;
  localparam [47:0] base_addr = 48'h1234_5678_9a00;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg write_test_request = 1'b0;
  reg read_test_request = 1'b0;
  reg [31:0] total_sector_count = 32'h0;
  reg [47:0] start_sector_addr = 48'h0;
  reg [2:0] pattern_select = 3'h0;
  reg stall = 1'b0;
  reg corrupt = 1'b0;
  wire test_busy_out;
  wire verify_fail_flag;
  wire write_cmd_out;
  wire read_cmd_out;
  wire [47:0] cmd_block_addr;
  wire [127:0] write_word_out;
  wire [127:0] read_word_in;
  wire read_word_valid;
  wire ctrl_wait_request;
  wire ctrl_busy_flag;
  integer bad_count = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer wr_words = 0;
  integer rd_cmds = 0;
  integer p;
  stpe_engine uut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .write_test_request(write_test_request),
    .read_test_request(read_test_request),
    .total_sector_count(total_sector_count),
    .start_sector_addr(start_sector_addr),
    .pattern_select(pattern_select), .test_busy_out(test_busy_out),
    .verify_fail_flag(verify_fail_flag), .write_cmd_out(write_cmd_out),
    .read_cmd_out(read_cmd_out), .cmd_block_addr(cmd_block_addr),
    .write_word_out(write_word_out), .read_word_in(read_word_in),
    .read_word_valid(read_word_valid),
    .ctrl_wait_request(ctrl_wait_request), .ctrl_busy_flag(ctrl_busy_flag)
  );
  stpe_ctrl_model u_ctrl (
    .ref_clk(ref_clk), .stall(stall), .corrupt(corrupt),
    .write_cmd_out(write_cmd_out), .read_cmd_out(read_cmd_out),
    .write_word_out(write_word_out), .read_word_in(read_word_in),
    .read_word_valid(read_word_valid),
    .ctrl_wait_request(ctrl_wait_request), .ctrl_busy_flag(ctrl_busy_flag)
  );
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (write_cmd_out && !ctrl_wait_request)
      wr_words <= wr_words + 1;
    if (read_cmd_out && !ctrl_wait_request)
      rd_cmds <= rd_cmds + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  task chk(input string nm, input [127:0] exp, input [127:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // One whole test: request, then wait for busy to clear
  task run(input rd, input [31:0] len, input [47:0] adr, input [2:0] pat);
    integer n;
    integer blk;
    begin
      blk = len >> 4;
      @(posedge ref_clk);
      wr_words <= 0;
      rd_cmds <= 0;
      total_sector_count <= len;
      start_sector_addr <= adr;
      pattern_select <= pat;
      read_test_request <= rd;
      write_test_request <= !rd;
      @(posedge ref_clk);
      read_test_request <= 1'b0;
      write_test_request <= 1'b0;
      #1;
      chk("busy", 1'b1, test_busy_out);
      n = 0;
      while (test_busy_out !== 1'b0 && n < 30000) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      chk("busy", 1'b0, test_busy_out);
      chk("words", rd ? 0 : blk * 512, wr_words);
      chk("reads", rd ? blk : 0, rd_cmds);
    end
  endtask
  task print_verdict;
    begin
      if (bad_count == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    stall <= 1'b1;
    // Odd length: the partial block must be dropped
    run(1'b0, 32'h25, base_addr, 3'h0);
    chk("hdr", {16'h0, base_addr}, u_ctrl.mem[0][63:0]);
    chk("hdr", {16'h0, base_addr + 48'h10}, u_ctrl.mem[512][63:0]);
    run(1'b1, 32'h25, base_addr, 3'h0);
    chk("fail", 1'b0, verify_fail_flag);
    corrupt <= 1'b1;
    run(1'b1, 32'h20, base_addr, 3'h0);
    chk("fail", 1'b1, verify_fail_flag);
    corrupt <= 1'b0;
    stall <= 1'b0;
    run(1'b0, 32'hf, base_addr, 3'h0);
    chk("fail", 1'b0, verify_fail_flag);
    for (p = 1; p < 5; p = p + 1) begin
      run(1'b0, 32'h10, base_addr, p[2:0]);
      if (p > 2) begin
        chk("fill", {128{p == 4}}, u_ctrl.mem[0]);
        chk("fill", {128{p == 4}}, u_ctrl.mem[511]);
      end else
        chk("hdr", {16'h0, base_addr}, u_ctrl.mem[0][63:0]);
    end
    // Long run moves ten blocks, more data than the buffer holds
    run(1'b0, 32'ha0, base_addr, 3'h2);
    stall <= 1'b1;
    run(1'b1, 32'ha0, base_addr, 3'h2);
    chk("fail", 1'b0, verify_fail_flag);
    print_verdict;
  end
endmodule // tb_top
